// ### shared/cksf_pkg.sv
// Constants, types and register map of the clock start-up and fail-safe controller
package cksf_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] CKSF_ADDR_CFG_HIGH  = 3'h0;
  localparam logic [2:0] CKSF_ADDR_CLK_CTRL  = 3'h1;
  localparam logic [2:0] CKSF_ADDR_OSC_TRIM  = 3'h2;
  localparam logic [2:0] CKSF_ADDR_IRQ_EN2   = 3'h3;
  localparam logic [2:0] CKSF_ADDR_FLAGS2    = 3'h4;
  localparam logic [2:0] CKSF_ADDR_USB_CFG   = 3'h5;

  // Reset values
  localparam logic [7:0] CKSF_RST_CFG_HIGH   = 8'h02;
  localparam logic [7:0] CKSF_RST_CLK_CTRL   = 8'h30;
  localparam logic [7:0] CKSF_RST_OSC_TRIM   = 8'h00;
  localparam logic [7:0] CKSF_RST_IRQ_EN2    = 8'h00;
  localparam logic [2:0] CKSF_RST_USB_CFG    = 3'h0;

  // Field positions
  localparam int CKSF_BIT_TWO_SPEED  = 7;
  localparam int CKSF_BIT_MON_EN     = 6;
  localparam int CKSF_BIT_PLL_FORCE  = 4;
  localparam int CKSF_BIT_RUN_STAT   = 3;
  localparam int CKSF_BIT_SRC_UPPER  = 1;
  localparam int CKSF_BIT_PLL_SOFT   = 6;
  localparam int CKSF_BIT_FAIL       = 7;

  // Timing counts
  localparam int CKSF_OST_CYCLES     = 1024;
  localparam int CKSF_SAMPLE_DIV     = 64;
  localparam int CKSF_SECONDARY_KHZ  = 32;

  // Primary source modes
  localparam logic [3:0] CKSF_MODE_LP  = 4'h0;
  localparam logic [3:0] CKSF_MODE_XT  = 4'h1;
  localparam logic [3:0] CKSF_MODE_HS  = 4'h2;
  localparam logic [3:0] CKSF_MODE_EC  = 4'h4;
  localparam logic [3:0] CKSF_MODE_RC  = 4'h6;
  localparam logic [3:0] CKSF_MODE_INT = 4'h8;

  // Start-up and fail-safe sequencing
  typedef enum logic [1:0] {
    CKSF_ST_OST,
    CKSF_ST_RUN,
    CKSF_ST_FAILED
  } cksf_state_t;

  // Source actually driving the system clock
  typedef enum logic [1:0] {
    CKSF_SRC_INTERNAL,
    CKSF_SRC_PRIMARY,
    CKSF_SRC_SECONDARY
  } cksf_src_t;

  // Configuration word layout
  typedef struct packed {
    logic       two_speed_start_enable;
    logic       clock_monitor_enable;
    logic       periph_clk_enable;
    logic       pll_force_config;
    logic [3:0] primary_source_select;
  } cksf_cfg_t;

  // Clock control layout; running status is read-only
  typedef struct packed {
    logic       idle_enable;
    logic [2:0] internal_freq_select;
    logic       primary_running_status;
    logic       internal_stable;
    logic [1:0] system_source_select;
  } cksf_ctrl_t;

endpackage

// ### core/cksf_core.sv
// Clock start-up, two-speed start and fail-safe clock monitor controller
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module cksf_core
  import cksf_pkg::*;
#(
  parameter int PRIMARY_KHZ = 12000   // Primary oscillator frequency in kHz
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        primary_osc_pin,
  input  wire logic        lf_osc_pin,
  input  wire logic        wake_pulse,
  input  wire logic        power_up_delay_timer_expire_pulse,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rd_data_q,
  output cksf_src_t        sys_src_q,
  output logic      [17:0] sys_freq_khz_q,
  output logic             cpu_halt_q,
  output logic             pll_on_q,
  output logic             primary_running_q,
  output logic             fail_safe_active_q,
  output logic             clock_fail_irq_q
);

  // Parameter checks
  if (PRIMARY_KHZ < 1 || PRIMARY_KHZ > 48000) begin : g_bad_khz
    $error("PRIMARY_KHZ must be 1 to 48000");
  end

  localparam logic [10:0] OST_LAST    = 11'(CKSF_OST_CYCLES - 1);
  localparam logic [4:0]  SAMPLE_LAST = 5'(CKSF_SAMPLE_DIV / 2 - 1);
  localparam logic [17:0] PRIMARY_F   = 18'(PRIMARY_KHZ);
  localparam logic [17:0] SECOND_F    = 18'(CKSF_SECONDARY_KHZ);

  // Software registers
  cksf_cfg_t   cfg_q;                 // Configuration word
  logic [2:0]  freq_sel_q;            // Internal frequency select
  logic        idle_q;                // Idle enable, stored only
  logic [1:0]  scs_q;                 // System source select
  logic [7:0]  trim_q;                // Trim register incl. soft PLL enable
  logic        fail_ie_q;             // Clock fail interrupt enable
  logic        fail_flag_q;           // Sticky clock fail flag
  logic [1:0]  cpu_div_q;             // CPU clock divider
  logic        usb_pre_q;             // USB prescale select, stored only

  // Synchronisers and detectors
  logic        p_meta_q;              // Primary pin, first stage
  logic        p_sync_q;              // Primary pin, second stage
  logic        p_last_q;              // Primary level one cycle ago
  logic        lf_meta_q;             // Low-frequency pin, first stage
  logic        lf_sync_q;             // Low-frequency pin, second stage
  logic        lf_last_q;             // Low-frequency level one cycle ago
  logic [4:0]  lf_cnt_q;              // Edge counter for divide by 64
  logic        sample_q;              // Sample clock level
  logic        latch_q;               // Fail detector latch

  // Sequencing
  cksf_state_t st_q;                  // Start-up state
  logic [10:0] ost_cnt_q;             // Start-up cycle count
  logic        fail_cond_q;           // Fail-safe condition

  // Decoded conditions
  logic        p_fall;                // Falling edge of primary clock
  logic        lf_rise;               // Rising edge of low-frequency clock
  logic        sample_rise;           // Sample clock about to rise
  logic        sample_fall;           // Sample clock about to fall
  logic        mode_crystal;          // Crystal mode with start-up timer
  logic        mode_no_ost;           // External clock or RC mode
  logic        mode_internal;         // Primary select names internal osc
  logic        two_speed_eff;         // Effective two-speed start-up
  logic        monitor_live;          // Monitor may flag a failure
  logic        fail_det;              // Failure seen this cycle
  logic        ost_done;              // Start-up timer expires this cycle
  logic        src_toggle;            // Software toggles upper select bit
  logic        restart;               // Start-up timer restart request
  logic        wr_ctrl;               // Write to clock control register
  cksf_ctrl_t  ctrl_view;             // Clock control read view
  cksf_src_t   src_d;                 // Next system source
  logic [17:0] freq_d;                // Next system frequency
  logic [17:0] base_f;                // Frequency before CPU divider
  logic        halt_d;                // Next halt state
  logic        pll_d;                 // Next PLL enable
  logic        run_stat_d;            // Next running status
  logic [7:0]  rd_d;                  // Next read data

  // Mode decode
  always_comb begin
    mode_crystal  = (cfg_q.primary_source_select == CKSF_MODE_LP) ||
                    (cfg_q.primary_source_select == CKSF_MODE_XT) ||
                    (cfg_q.primary_source_select == CKSF_MODE_HS);
    mode_no_ost   = (cfg_q.primary_source_select == CKSF_MODE_EC) ||
                    (cfg_q.primary_source_select == CKSF_MODE_RC);
    mode_internal = !mode_crystal && !mode_no_ost;
    // Monitor enable implies two-speed start
    two_speed_eff = cfg_q.two_speed_start_enable || cfg_q.clock_monitor_enable;
  end

  // Register strobes and restart causes
  always_comb begin
    wr_ctrl    = reg_wr_en && (reg_addr == CKSF_ADDR_CLK_CTRL);
    src_toggle = wr_ctrl && (reg_wr_data[CKSF_BIT_SRC_UPPER] != scs_q[1]);
    // Wake-up and delay-timer expiry send the sequencer back to the start-up timer state
    restart    = wake_pulse || power_up_delay_timer_expire_pulse ||
                 (src_toggle && st_q == CKSF_ST_FAILED);
  end

  // Two-flop synchronisers for both oscillator pins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      p_meta_q  <= 1'b0;
      p_sync_q  <= 1'b0;
      p_last_q  <= 1'b0;
      lf_meta_q <= 1'b0;
      lf_sync_q <= 1'b0;
      lf_last_q <= 1'b0;
    end else begin
      p_meta_q  <= primary_osc_pin;
      p_sync_q  <= p_meta_q;
      p_last_q  <= p_sync_q;
      lf_meta_q <= lf_osc_pin;
      lf_sync_q <= lf_meta_q;
      lf_last_q <= lf_sync_q;
    end
  end

  // Edge detection on synchronised levels only
  always_comb begin
    p_fall      = p_last_q && !p_sync_q;
    lf_rise     = !lf_last_q && lf_sync_q;
    sample_rise = lf_rise && (lf_cnt_q == SAMPLE_LAST) && !sample_q;
    sample_fall = lf_rise && (lf_cnt_q == SAMPLE_LAST) && sample_q;
  end

  // Sample clock: toggles every 32 low-frequency edges, period 64
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lf_cnt_q <= 5'h00;
      sample_q <= 1'b0;
    end else if (lf_rise) begin
      if (lf_cnt_q == SAMPLE_LAST) begin
        lf_cnt_q <= 5'h00;
        sample_q <= !sample_q;
      end else begin
        lf_cnt_q <= lf_cnt_q + 5'h01;
      end
    end
  end

  // Failure decision: a whole high half-cycle without a primary fall
  always_comb begin
    monitor_live = cfg_q.clock_monitor_enable && !mode_internal &&
                   (st_q == CKSF_ST_RUN);
    fail_det     = monitor_live && sample_fall && !latch_q && !p_fall;
  end

  // Detector latch, primed when monitoring begins so no false failure
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= 1'b0;
    end else if (p_fall || ost_done) begin
      latch_q <= 1'b1;
    end else if (sample_rise) begin
      latch_q <= 1'b0;
    end
  end

  // Start-up timer expiry
  always_comb begin
    if (st_q != CKSF_ST_OST) begin
      ost_done = 1'b0;
    end else if (mode_crystal) begin
      ost_done = p_fall && (ost_cnt_q == OST_LAST);
    end else begin
      // No timer for external clock, RC or internal primary
      ost_done = 1'b1;
    end
  end

  // Start-up timer counter, counting primary oscillations
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ost_cnt_q <= 11'h000;
    end else if (restart || ost_done) begin
      ost_cnt_q <= 11'h000;
    end else if (st_q == CKSF_ST_OST && p_fall) begin
      ost_cnt_q <= ost_cnt_q + 11'h001;
    end
  end

  // Start-up and fail-safe state machine
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= CKSF_ST_OST;
    end else if (restart) begin
      st_q <= CKSF_ST_OST;
    end else begin
      unique case (st_q)
        CKSF_ST_OST: begin
          if (ost_done) begin
            st_q <= CKSF_ST_RUN;
          end
        end
        CKSF_ST_RUN: begin
          if (fail_det) begin
            st_q <= CKSF_ST_FAILED;
          end
        end
        CKSF_ST_FAILED: begin
          // Held here until a restart: software toggles the upper select bit, or wake-up or delay-timer expiry
          st_q <= CKSF_ST_FAILED;
        end
        default: begin
          st_q <= CKSF_ST_OST;
        end
      endcase
    end
  end

  // Fail-safe condition: set on failure, cleared at timer expiry
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fail_cond_q <= 1'b0;
    end else if (fail_det) begin
      fail_cond_q <= 1'b1;
    end else if (ost_done) begin
      fail_cond_q <= 1'b0;
    end
  end

  // Sticky fail flag: a failure in the clearing cycle wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fail_flag_q <= 1'b0;
    end else if (fail_det) begin
      fail_flag_q <= 1'b1;
    end else if (reg_wr_en && reg_addr == CKSF_ADDR_FLAGS2) begin
      // Clear accepted whatever the fail-safe condition
      fail_flag_q <= reg_wr_data[CKSF_BIT_FAIL];
    end
  end

  // Configuration, trim, enable and USB divider registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q     <= cksf_cfg_t'(CKSF_RST_CFG_HIGH);
      trim_q    <= CKSF_RST_OSC_TRIM;
      fail_ie_q <= CKSF_RST_IRQ_EN2[CKSF_BIT_FAIL];
      cpu_div_q <= CKSF_RST_USB_CFG[1:0];
      usb_pre_q <= CKSF_RST_USB_CFG[2];
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        CKSF_ADDR_CFG_HIGH: begin
          cfg_q <= cksf_cfg_t'(reg_wr_data);
        end
        CKSF_ADDR_OSC_TRIM: begin
          trim_q <= reg_wr_data;
        end
        CKSF_ADDR_IRQ_EN2: begin
          fail_ie_q <= reg_wr_data[CKSF_BIT_FAIL];
        end
        CKSF_ADDR_USB_CFG: begin
          cpu_div_q <= reg_wr_data[1:0];
          usb_pre_q <= reg_wr_data[2];
        end
        default: begin
          // Other addresses hold no register here
        end
      endcase
    end
  end

  // Clock control register, writable fields only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_q     <= CKSF_RST_CLK_CTRL[7];
      freq_sel_q <= CKSF_RST_CLK_CTRL[6:4];
      scs_q      <= CKSF_RST_CLK_CTRL[1:0];
    end else if (wr_ctrl) begin
      idle_q     <= reg_wr_data[7];
      freq_sel_q <= reg_wr_data[6:4];
      scs_q      <= reg_wr_data[1:0];
    end
  end

  // Internal oscillator frequency in kHz for a select code
  function automatic logic [17:0] int_khz(input logic [2:0] sel);
    logic [17:0] f;
    f = 18'd31;
    unique case (sel)
      3'h0: f = 18'd31;
      3'h1: f = 18'd250;
      3'h2: f = 18'd500;
      3'h3: f = 18'd1000;
      3'h4: f = 18'd2000;
      3'h5: f = 18'd4000;
      3'h6: f = 18'd8000;
      3'h7: f = 18'd16000;
    endcase
    return f;
  endfunction

  // Source selection, PLL and halt
  always_comb begin
    // PLL forced by configuration, otherwise under software
    pll_d = cfg_q.pll_force_config || trim_q[CKSF_BIT_PLL_SOFT];
    halt_d = 1'b0;
    if (scs_q[1]) begin
      src_d = CKSF_SRC_INTERNAL;
    end else if (st_q == CKSF_ST_FAILED || fail_cond_q) begin
      // A failure forces internal even over the secondary select
      src_d = CKSF_SRC_INTERNAL;
    end else if (scs_q[0]) begin
      src_d = CKSF_SRC_SECONDARY;
    end else if (mode_internal) begin
      src_d = CKSF_SRC_INTERNAL;
    end else if (st_q == CKSF_ST_OST && two_speed_eff) begin
      src_d = CKSF_SRC_INTERNAL;
    end else begin
      src_d = CKSF_SRC_PRIMARY;
      halt_d = (st_q == CKSF_ST_OST) && mode_crystal;
    end
    run_stat_d = (src_d == CKSF_SRC_PRIMARY) ||
                 (mode_internal && scs_q == 2'b00);
  end

  // System frequency: primary through PLL and CPU divider, else other
  always_comb begin
    base_f = pll_d ? {PRIMARY_F[15:0], 2'b00} : PRIMARY_F;
    unique case (src_d)
      CKSF_SRC_PRIMARY: begin
        unique case (cpu_div_q)
          2'b00: freq_d = base_f;
          2'b01: freq_d = base_f >> 1;
          2'b10: freq_d = base_f / 18'd3;
          2'b11: freq_d = base_f >> 2;
        endcase
      end
      CKSF_SRC_SECONDARY: begin
        freq_d = SECOND_F;
      end
      default: begin
        freq_d = int_khz(freq_sel_q);
      end
    endcase
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    ctrl_view.idle_enable            = idle_q;
    ctrl_view.internal_freq_select   = freq_sel_q;
    ctrl_view.primary_running_status = primary_running_q;
    ctrl_view.internal_stable        = 1'b1;
    ctrl_view.system_source_select   = scs_q;
    unique case (reg_addr)
      CKSF_ADDR_CFG_HIGH: rd_d = cfg_q;
      CKSF_ADDR_CLK_CTRL: rd_d = ctrl_view;
      CKSF_ADDR_OSC_TRIM: rd_d = trim_q;
      CKSF_ADDR_IRQ_EN2:  rd_d = {fail_ie_q, 7'h00};
      CKSF_ADDR_FLAGS2:   rd_d = {fail_flag_q, 7'h00};
      CKSF_ADDR_USB_CFG:  rd_d = {5'h00, usb_pre_q, cpu_div_q};
      default:            rd_d = 8'h00;
    endcase
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rd_data_q <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data_q <= rd_d;
    end else begin
      reg_rd_data_q <= 8'h00;
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sys_src_q          <= CKSF_SRC_INTERNAL;
      sys_freq_khz_q     <= 18'h00000;
      cpu_halt_q         <= 1'b0;
      pll_on_q           <= 1'b0;
      primary_running_q  <= 1'b0;
      fail_safe_active_q <= 1'b0;
      clock_fail_irq_q   <= 1'b0;
    end else begin
      sys_src_q          <= src_d;
      sys_freq_khz_q     <= freq_d;
      cpu_halt_q         <= halt_d;
      pll_on_q           <= pll_d;
      primary_running_q  <= run_stat_d;
      fail_safe_active_q <= fail_cond_q;
      clock_fail_irq_q   <= fail_flag_q && fail_ie_q;
    end
  end

endmodule

// ### test/cksf_osc_model.sv
// Behavioural primary oscillator that can be stopped to emulate a failure
`timescale 1ns/1ps

module cksf_osc_model #(
  parameter int HALF_NS = 50  // Half period of the oscillator
) (
  input  wire logic run,      // High while the oscillator swings
  output logic      osc_pin   // Oscillator output level
);
  // Swing while running; a dead oscillator parks high, so no falling edge comes
  initial begin
    osc_pin = 1'b1;
    #3;
    forever begin
      #(HALF_NS);
      osc_pin = run ? ~osc_pin : 1'b1;
    end
  end
endmodule

// ### test/cksf_core_asserts.sv
// Concurrent checks on the ports of the clock controller
`timescale 1ns/1ps

module cksf_core_asserts
  import cksf_pkg::*;
#(
  parameter int PRIMARY_KHZ = 12000  // Primary frequency in kHz
) (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        primary_osc_pin,
  input wire logic        lf_osc_pin,
  input wire logic        wake_pulse,
  input wire logic        power_up_delay_timer_expire_pulse,
  input wire logic [2:0]  reg_addr,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rd_data_q,
  input wire cksf_src_t   sys_src_q,
  input wire logic [17:0] sys_freq_khz_q,
  input wire logic        cpu_halt_q,
  input wire logic        pll_on_q,
  input wire logic        primary_running_q,
  input wire logic        fail_safe_active_q,
  input wire logic        clock_fail_irq_q
);
  logic [3:0] mode_q;    // Primary source select mirrored from configuration writes
  logic       mode_int;  // Primary select names the internal oscillator

  // Mirror of the source select; an internal primary legally reports running
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= CKSF_RST_CFG_HIGH[3:0];
    end else if (reg_wr_en && reg_addr == CKSF_ADDR_CFG_HIGH) begin
      mode_q <= reg_wr_data[3:0];
    end
  end

  // Any code other than the crystal, external clock and RC codes is internal
  always_comb begin
    mode_int = !(mode_q inside {CKSF_MODE_LP, CKSF_MODE_XT, CKSF_MODE_HS,
                                CKSF_MODE_EC, CKSF_MODE_RC});
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  halt_on_primary_a: assert property (cpu_halt_q |-> sys_src_q == CKSF_SRC_PRIMARY)
    else $error("halt while not on primary");
  status_internal_a: assert property (sys_src_q == CKSF_SRC_INTERNAL
    && $past(sys_src_q) == CKSF_SRC_INTERNAL && !mode_int && !$past(mode_int)
    |-> !primary_running_q)
    else $error("running status set on internal clock");
  fail_switch_a: assert property ($rose(fail_safe_active_q)
    |-> sys_src_q == CKSF_SRC_INTERNAL) else $error("failure did not switch to internal");
  no_return_a: assert property (fail_safe_active_q |-> sys_src_q != CKSF_SRC_PRIMARY)
    else $error("returned to failed clock");
  irq_cause_a: assert property ($rose(clock_fail_irq_q)
    |-> fail_safe_active_q || $past(reg_wr_en) || $past(reg_wr_en, 2))
    else $error("interrupt without failure or write");
  flag_clear_a: assert property (reg_wr_en && reg_addr == CKSF_ADDR_FLAGS2
    && !reg_wr_data[CKSF_BIT_FAIL] && fail_safe_active_q |-> ##[1:3] !clock_fail_irq_q)
    else $error("flag clear refused during fail-safe");
  pll_force_a: assert property (reg_wr_en && reg_addr == CKSF_ADDR_CFG_HIGH
    && reg_wr_data[CKSF_BIT_PLL_FORCE] |-> ##[1:3] pll_on_q) else $error("forced pll off");
  pll_soft_a: assert property (reg_wr_en && reg_addr == CKSF_ADDR_OSC_TRIM
    && reg_wr_data[CKSF_BIT_PLL_SOFT] |-> ##[1:3] pll_on_q) else $error("soft pll off");
  fail_freq_a: assert property ($rose(fail_safe_active_q) |-> ##[0:2] sys_freq_khz_q
    inside {18'd31, 18'd250, 18'd500, 18'd1000, 18'd2000, 18'd4000, 18'd8000, 18'd16000})
    else $error("fail-over frequency not internal");
  detect_idle_a: assert property (cpu_halt_q |-> !fail_safe_active_q)
    else $error("failure flagged during start-up");
endmodule

bind cksf_core cksf_core_asserts #(.PRIMARY_KHZ(PRIMARY_KHZ)) cksf_core_asserts_i (
  .core_clk(core_clk), .resetn(resetn), .primary_osc_pin(primary_osc_pin),
  .lf_osc_pin(lf_osc_pin), .wake_pulse(wake_pulse), .power_up_delay_timer_expire_pulse(power_up_delay_timer_expire_pulse),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q), .sys_src_q(sys_src_q),
  .sys_freq_khz_q(sys_freq_khz_q), .cpu_halt_q(cpu_halt_q), .pll_on_q(pll_on_q),
  .primary_running_q(primary_running_q), .fail_safe_active_q(fail_safe_active_q),
  .clock_fail_irq_q(clock_fail_irq_q));

// ### test/clock_startup_failsafe_ctrl_bench.sv
// Self-checking bench for the clock start-up and fail-safe controller
`timescale 1ns/1ps

module clock_startup_failsafe_ctrl_bench;
  import cksf_pkg::*;
  localparam int          PK      = 12000;                    // Primary in kHz
  localparam logic [17:0] SRC_PRI = 18'(CKSF_SRC_PRIMARY);
  localparam logic [17:0] SRC_INT = 18'(CKSF_SRC_INTERNAL);
  logic        core_clk, resetn, lf_osc_pin, wake_pulse, power_up_delay_timer_expire_pulse;
  logic        reg_wr_en, reg_rd_en, osc_run, primary_osc_pin;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wr_data, reg_rd_data_q, rd_d;
  cksf_src_t   sys_src_q;
  logic [17:0] sys_freq_khz_q;
  logic        cpu_halt_q, pll_on_q, primary_running_q, fail_safe_active_q, clock_fail_irq_q;
  int          n_errors, tests_run, cycles, i, p, dv, seed;

  cksf_core #(.PRIMARY_KHZ(PK)) cksf_core_i (
    .core_clk(core_clk), .resetn(resetn), .primary_osc_pin(primary_osc_pin),
    .lf_osc_pin(lf_osc_pin), .wake_pulse(wake_pulse), .power_up_delay_timer_expire_pulse(power_up_delay_timer_expire_pulse),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q), .sys_src_q(sys_src_q),
    .sys_freq_khz_q(sys_freq_khz_q), .cpu_halt_q(cpu_halt_q), .pll_on_q(pll_on_q),
    .primary_running_q(primary_running_q), .fail_safe_active_q(fail_safe_active_q),
    .clock_fail_irq_q(clock_fail_irq_q));
  cksf_osc_model #(.HALF_NS(50)) cksf_osc_model_i (.run(osc_run), .osc_pin(primary_osc_pin));

  // Core clock at 100 MHz and a fast stand-in for the low-frequency oscillator
  always #5 core_clk = ~core_clk;
  always #40 lf_osc_pin = ~lf_osc_pin;

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 70000) begin
      n_errors++;
      finish_test;
    end
  end

  // Expected frequency from input, multiplier and divider code
  function automatic logic [17:0] exp_freq(int pll, int div);
    return 18'(PK * (pll ? 4 : 1) / (div + 1));
  endfunction

  task automatic chk(logic [17:0] seen, logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge core_clk);
    reg_wr_en   <= 1'b0;
  endtask

  // Read data stands in the cycle after the strobe only
  task automatic rd(logic [2:0] a);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    rd_d = reg_rd_data_q;
  endtask

  task automatic finish_test;
    $display("n_errors=%0d tests_run=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 32'h081da42e;
    {n_errors, tests_run, cycles} = '0;
    {core_clk, resetn, lf_osc_pin, wake_pulse, power_up_delay_timer_expire_pulse} = '0;
    {reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = '0;
    osc_run = 1'b1;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    step(2);
    chk(18'(cpu_halt_q), 18'h1);
    chk(18'(sys_src_q), SRC_PRI);
    // Reset values; index 1 masked over its status bits, 6 and 7 unmapped
    for (i = 0; i < 8; i++) begin
      rd(3'(i));
      if (i == 1) chk(18'(rd_d & 8'hF3), 18'h30);
      else chk(18'(rd_d), (i == 0) ? 18'h2 : 18'h0);
    end
    step(9880);
    chk(18'(cpu_halt_q), 18'h1);
    step(700);
    chk(18'(cpu_halt_q), 18'h0);
    chk(18'(primary_running_q), 18'h1);
    // Every multiplier and divider setting, with random trim bits alongside
    wr(CKSF_ADDR_CLK_CTRL, 8'h70);
    for (p = 0; p < 2; p++) begin
      for (dv = 0; dv < 4; dv++) begin
        wr(CKSF_ADDR_OSC_TRIM, 8'(p << 6) | (8'($random(seed)) & 8'h3F));
        wr(CKSF_ADDR_USB_CFG, 8'(dv));
        step(4);
        chk(sys_freq_khz_q, exp_freq(p, dv));
        chk(18'(pll_on_q), 18'(p));
      end
    end
    wr(CKSF_ADDR_OSC_TRIM, 8'h00);
    wr(CKSF_ADDR_CFG_HIGH, 8'h12);
    step(4);
    chk(18'(pll_on_q), 18'h1);
    wr(CKSF_ADDR_CLK_CTRL, 8'h72);
    step(4);
    chk(sys_freq_khz_q, 18'd16000);
    wr(CKSF_ADDR_CLK_CTRL, 8'h70);
    // Monitor enable alone must bring two-speed start after the delay timer
    wr(CKSF_ADDR_CFG_HIGH, 8'h42);
    @(posedge core_clk) power_up_delay_timer_expire_pulse <= 1'b1;
    @(posedge core_clk) power_up_delay_timer_expire_pulse <= 1'b0;
    step(4);
    chk(18'(sys_src_q), SRC_INT);
    chk(18'(cpu_halt_q), 18'h0);
    rd(CKSF_ADDR_CLK_CTRL);
    chk(18'(rd_d[CKSF_BIT_RUN_STAT]), 18'h0);
    step(10600);
    chk(18'(sys_src_q), SRC_PRI);
    rd(CKSF_ADDR_CLK_CTRL);
    chk(18'(rd_d[CKSF_BIT_RUN_STAT]), 18'h1);
    // Stop the primary and watch the fail-over
    wr(CKSF_ADDR_IRQ_EN2, 8'h80);
    chk(18'(fail_safe_active_q), 18'h0);
    @(posedge core_clk) osc_run <= 1'b0;
    for (i = 0; i < 1500 && fail_safe_active_q !== 1'b1; i++) step(1);
    chk(18'(sys_src_q), SRC_INT);
    chk(sys_freq_khz_q, 18'd16000);
    step(3);
    chk(18'(clock_fail_irq_q), 18'h1);
    @(posedge core_clk) osc_run <= 1'b1;
    step(12000);
    chk(18'(sys_src_q), SRC_INT);
    rd(CKSF_ADDR_FLAGS2);
    chk(18'(rd_d), 18'h80);
    wr(CKSF_ADDR_FLAGS2, 8'h00);
    rd(CKSF_ADDR_FLAGS2);
    chk(18'(rd_d), 18'h0);
    chk(18'(fail_safe_active_q), 18'h1);
    // Toggle the upper select bit to restart the timer
    wr(CKSF_ADDR_CLK_CTRL, 8'h72);
    wr(CKSF_ADDR_CLK_CTRL, 8'h70);
    step(500);
    chk(18'(sys_src_q), SRC_INT);
    step(10400);
    chk(18'(fail_safe_active_q), 18'h0);
    chk(18'(sys_src_q), SRC_PRI);
    // External clock mode skips the timer after wake-up
    wr(CKSF_ADDR_CFG_HIGH, 8'h04);
    @(posedge core_clk) wake_pulse <= 1'b1;
    @(posedge core_clk) wake_pulse <= 1'b0;
    step(5);
    chk(18'(sys_src_q), SRC_PRI);
    chk(18'(cpu_halt_q), 18'h0);
    finish_test;
  end
endmodule
